// ---- rtl/tilu_pkg.sv ----
// constants and types shared by the timer, interrupt and low-power unit
package tilu_pkg;

	// register map (byte offsets on the plain register port)
	localparam logic [7:0] TILU_OFF_COUNT   = 8'h08;
	localparam logic [7:0] TILU_OFF_CONTROL = 8'h09;

	// control register field positions
	localparam int TILU_BIT_REQ_FLAG  = 7;
	localparam int TILU_BIT_REQ_MASK  = 6;
	localparam int TILU_BIT_CLK_SEL   = 5;
	localparam int TILU_BIT_PIN_EN    = 4;
	localparam int TILU_BIT_PRE_ZERO  = 3;
	localparam int TILU_PSEL_LSB      = 0;
	localparam int TILU_PSEL_MSB      = 2;

	// widths
	localparam int TILU_COUNT_W = 8;
	localparam int TILU_PRE_W   = 7;
	localparam int TILU_VEC_W   = 13;

	// values after reset, then the count values one and zero used by the compares
	localparam logic [7:0] TILU_COUNT_POR   = 8'hff;
	localparam logic       TILU_FLAG_RST    = 1'b0;
	localparam logic       TILU_MASK_RST    = 1'b1;
	localparam logic       TILU_SEL_POR     = 1'b0;
	localparam logic       TILU_PIN_EN_POR  = 1'b0;
	localparam logic [2:0] TILU_PSEL_POR    = 3'h0;
	localparam logic [6:0] TILU_PRE_RST     = 7'h00;
	localparam logic [7:0] TILU_COUNT_ONE   = 8'h01;
	localparam logic [7:0] TILU_COUNT_ZERO  = 8'h00;

	// service routine vectors (address of the high byte)
	localparam logic [12:0] TILU_VEC_TIMER_WAIT = 13'h1ff6;
	localparam logic [12:0] TILU_VEC_TIMER      = 13'h1ff8;
	localparam logic [12:0] TILU_VEC_EXT        = 13'h1ffa;
	localparam logic [12:0] TILU_VEC_SOFT       = 13'h1ffc;
	localparam logic [12:0] TILU_VEC_NONE       = 13'h0000;

	// spacing the far side keeps between pulses, on top of the routine length
	localparam int TILU_PULSE_GAP_CYC = 20;

	typedef enum logic [1:0] {
		TILU_RUN,
		TILU_STOP,
		TILU_WAIT
	} tilu_state_t;

endpackage

// ---- rtl/tilu_timer_irq.sv ----
// timer, interrupt routing and stop/wait control unit
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
module tilu_timer_irq #(
	parameter int PRE_W = tilu_pkg::TILU_PRE_W
) (
	// clock and resets
	input  wire logic        clk_sys_in,
	input  wire logic        rst_in,
	input  wire logic        por_in,
	// register port
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic [7:0]  reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic      [7:0]  reg_rdata_out,
	// pins
	input  wire logic        irq_n_in,
	input  wire logic        timer_pin_in,
	// core sequencer
	input  wire logic        cycle_tick_in,
	input  wire logic        instr_boundary_in,
	input  wire logic        i_mask_in,
	input  wire logic        soft_trap_op_in,
	input  wire logic        stop_op_in,
	input  wire logic        wait_op_in,
	input  wire logic        core_as_in,
	input  wire logic        core_ds_in,
	input  wire logic        core_rw_n_in,
	// interrupt answer to the core
	output logic             irq_take_out,
	output logic      [12:0] irq_vector_out,
	output logic             set_i_mask_out,
	output logic             clear_i_mask_out,
	output logic             wake_out,
	// low-power pin states
	output logic             address_strobe_line_out,
	output logic             data_strobe_line_out,
	output logic             rw_n_out,
	output logic             bus_input_out,
	output logic             hold_addr_out,
	output logic             stop_active_out,
	output logic             wait_active_out
);

	// input synchronisers, three stages with agreement filter
	logic irq_s1_q, irq_s2_q, irq_s3_q, irq_lvl_q;
	logic tpin_s1_q, tpin_s2_q, tpin_s3_q, tpin_lvl_q, tpin_prev_q;

	always_ff @(posedge clk_sys_in) begin
		irq_s1_q  <= irq_n_in;
		irq_s2_q  <= irq_s1_q;
		irq_s3_q  <= irq_s2_q;
		tpin_s1_q <= timer_pin_in;
		tpin_s2_q <= tpin_s1_q;
		tpin_s3_q <= tpin_s2_q;
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in || por_in) begin
			irq_lvl_q   <= 1'b1;
			tpin_lvl_q  <= 1'b0;
			tpin_prev_q <= 1'b0;
		end else begin
			if (irq_s2_q == irq_s3_q) begin
				irq_lvl_q <= irq_s3_q;
			end
			if (tpin_s2_q == tpin_s3_q) begin
				tpin_lvl_q <= tpin_s3_q;
			end
			tpin_prev_q <= tpin_lvl_q;
		end
	end

	// control and count state
	logic                   flag_q, flag_d;
	logic                   mask_q, mask_d;
	logic                   clk_sel_q;
	logic                   pin_en_q;
	logic [2:0]             psel_q;
	logic [PRE_W-1:0]       pre_q, pre_d;
	logic [7:0]             count_q, count_d;
	tilu_pkg::tilu_state_t  state_q, state_d;

	// register decode
	wire wr_count   = reg_wr_in && (reg_addr_in == tilu_pkg::TILU_OFF_COUNT);
	wire wr_control = reg_wr_in && (reg_addr_in == tilu_pkg::TILU_OFF_CONTROL);
	wire pre_clear  = wr_control && reg_wdata_in[tilu_pkg::TILU_BIT_PRE_ZERO];

	// count clock selection
	wire in_stop      = (state_q == tilu_pkg::TILU_STOP);
	wire in_wait      = (state_q == tilu_pkg::TILU_WAIT);
	wire in_run       = (state_q == tilu_pkg::TILU_RUN);
	// instruction clock keeps running in wait, halted in stop
	wire int_tick     = cycle_tick_in && !in_stop;
	wire pin_fall     = tpin_prev_q && !tpin_lvl_q;
	wire mode_int     = !pin_en_q && !clk_sel_q;
	wire mode_gated   = pin_en_q && !clk_sel_q;
	wire mode_ext     = pin_en_q && clk_sel_q;
	// pin-only counting is the one source that runs in stop
	wire count_tick   = (mode_int && int_tick)
	                  | (mode_gated && int_tick && tpin_lvl_q)
	                  | (mode_ext && pin_fall);

	// prescaler tap: code 0 passes every tick, code n the falling edge of bit n-1
	wire [PRE_W-1:0] pre_inc = pre_q + {{(PRE_W-1){1'b0}}, 1'b1};
	function automatic logic tap_fall(input logic [PRE_W-1:0] cur, input logic [PRE_W-1:0] nxt,
	                                  input logic [2:0] sel);
		logic r;
		r = 1'b1;
		if (sel != 3'h0) begin
			r = cur[sel - 3'h1] && !nxt[sel - 3'h1];
		end
		return r;
	endfunction
	wire cnt_step   = count_tick && tap_fall(pre_q, pre_inc, psel_q);
	wire hit_zero   = cnt_step && (count_q == tilu_pkg::TILU_COUNT_ONE) && !wr_count;

	always_comb begin
		pre_d = pre_q;
		if (pre_clear) begin
			pre_d = tilu_pkg::TILU_PRE_RST;
		end else if (count_tick) begin
			pre_d = pre_inc;
		end
	end

	always_comb begin
		count_d = count_q;
		if (wr_count) begin
			count_d = reg_wdata_in;
		end else if (cnt_step) begin
			count_d = count_q - 8'h01;
		end
	end

	// interrupt decision
	wire stop_go    = instr_boundary_in && in_run && stop_op_in;
	wire wait_go    = instr_boundary_in && in_run && wait_op_in;
	wire ext_low    = !irq_lvl_q;
	wire tmr_req    = flag_q && !mask_q;
	wire ext_pend   = ext_low && !i_mask_in;
	wire tmr_pend   = tmr_req && !i_mask_in;
	// the mask was cleared on entry, so a wake ignores the core copy
	wire wake_stop  = in_stop && ext_low;
	wire wake_wait  = in_wait && (ext_low || tmr_req);
	wire wake       = wake_stop || wake_wait;
	wire run_pick   = instr_boundary_in && in_run && !stop_op_in && !wait_op_in;
	wire take_ext   = (run_pick && ext_pend) || (wake && ext_low);
	wire take_tmr   = !take_ext && ((run_pick && tmr_pend) || wake_wait);
	wire take_soft  = run_pick && !ext_pend && !tmr_pend && soft_trap_op_in;
	wire take_any   = take_ext || take_tmr || take_soft;

	wire [12:0] vec_sel = take_ext  ? tilu_pkg::TILU_VEC_EXT
	                    : take_tmr  ? (wake_wait ? tilu_pkg::TILU_VEC_TIMER_WAIT
	                                             : tilu_pkg::TILU_VEC_TIMER)
	                    : take_soft ? tilu_pkg::TILU_VEC_SOFT
	                    : irq_vector_out;

	// flag and mask; hardware set wins over software clear
	always_comb begin
		flag_d = flag_q;
		mask_d = mask_q;
		if (wr_control) begin
			flag_d = reg_wdata_in[tilu_pkg::TILU_BIT_REQ_FLAG];
			mask_d = reg_wdata_in[tilu_pkg::TILU_BIT_REQ_MASK];
		end
		if (hit_zero) begin
			flag_d = 1'b1;
		end
		if (stop_go) begin
			flag_d = 1'b0;
			mask_d = 1'b1;
		end
	end

	always_comb begin
		state_d = state_q;
		if (stop_go) begin
			state_d = tilu_pkg::TILU_STOP;
		end else if (wait_go) begin
			state_d = tilu_pkg::TILU_WAIT;
		end else if (wake) begin
			state_d = tilu_pkg::TILU_RUN;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (por_in) begin
			count_q   <= tilu_pkg::TILU_COUNT_POR;
			clk_sel_q <= tilu_pkg::TILU_SEL_POR;
			pin_en_q  <= tilu_pkg::TILU_PIN_EN_POR;
			psel_q    <= tilu_pkg::TILU_PSEL_POR;
			pre_q     <= tilu_pkg::TILU_PRE_RST;
		end else begin
			count_q <= count_d;
			pre_q   <= pre_d;
			if (wr_control) begin
				clk_sel_q <= reg_wdata_in[tilu_pkg::TILU_BIT_CLK_SEL];
				pin_en_q  <= reg_wdata_in[tilu_pkg::TILU_BIT_PIN_EN];
				psel_q    <= reg_wdata_in[tilu_pkg::TILU_PSEL_MSB:tilu_pkg::TILU_PSEL_LSB];
			end
		end
	end

	// reset pin leaves the select bits, prescaler and count alone
	always_ff @(posedge clk_sys_in) begin
		if (rst_in || por_in) begin
			flag_q       <= tilu_pkg::TILU_FLAG_RST;
			mask_q       <= tilu_pkg::TILU_MASK_RST;
			state_q      <= tilu_pkg::TILU_RUN;
		end else begin
			flag_q       <= flag_d;
			mask_q       <= mask_d;
			state_q      <= state_d;
		end
	end

	// answers to the core and the register port
	wire [7:0] control_rd = {flag_q, mask_q, clk_sel_q, pin_en_q, 1'b0, psel_q};
	wire [7:0] rd_sel     = (reg_addr_in == tilu_pkg::TILU_OFF_COUNT)   ? count_q
	                      : (reg_addr_in == tilu_pkg::TILU_OFF_CONTROL) ? control_rd
	                      : 8'h00;
	wire       lp_next    = (state_d != tilu_pkg::TILU_RUN);

	always_ff @(posedge clk_sys_in) begin
		if (rst_in || por_in) begin
			reg_rdata_out           <= 8'h00;
			irq_take_out            <= 1'b0;
			irq_vector_out          <= tilu_pkg::TILU_VEC_NONE;
			set_i_mask_out          <= 1'b0;
			clear_i_mask_out        <= 1'b0;
			wake_out                <= 1'b0;
			address_strobe_line_out <= 1'b0;
			data_strobe_line_out    <= 1'b0;
			rw_n_out                <= 1'b1;
			bus_input_out           <= 1'b1;
			hold_addr_out           <= 1'b0;
			stop_active_out         <= 1'b0;
			wait_active_out         <= 1'b0;
		end else begin
			reg_rdata_out           <= reg_rd_in ? rd_sel : 8'h00;
			irq_take_out            <= take_any;
			irq_vector_out          <= vec_sel;
			set_i_mask_out          <= take_any;
			clear_i_mask_out        <= stop_go || wait_go;
			wake_out                <= wake;
			address_strobe_line_out <= lp_next ? 1'b0 : core_as_in;
			data_strobe_line_out    <= lp_next ? 1'b0 : core_ds_in;
			rw_n_out                <= lp_next ? 1'b1 : core_rw_n_in;
			bus_input_out           <= lp_next ? 1'b1 : core_rw_n_in;
			hold_addr_out           <= lp_next;
			stop_active_out         <= (state_d == tilu_pkg::TILU_STOP);
			wait_active_out         <= (state_d == tilu_pkg::TILU_WAIT);
		end
	end

	// checks
	a_count_wrap: assert property (@(posedge clk_sys_in) disable iff (rst_in || por_in)
		(cnt_step && !wr_count && count_q == tilu_pkg::TILU_COUNT_ZERO) |=> (count_q == 8'hff))
		else $error("counter did not wrap to ff");

	a_zero_sets_flag: assert property (@(posedge clk_sys_in) disable iff (rst_in || por_in)
		(hit_zero && !stop_go) |=> flag_q)
		else $error("reaching zero did not set the request flag");

	a_stop_entry_flags: assert property (@(posedge clk_sys_in) disable iff (rst_in || por_in)
		stop_go |=> (!flag_q && mask_q && in_stop && clear_i_mask_out && stop_active_out))
		else $error("stop entry did not clear flag and set mask");

	a_ext_first: assert property (@(posedge clk_sys_in) disable iff (rst_in || por_in)
		(run_pick && ext_pend && tmr_pend) |=> (irq_take_out && irq_vector_out == 13'h1ffa))
		else $error("timer served ahead of external");

	a_lp_pin_state: assert property (@(posedge clk_sys_in) disable iff (rst_in || por_in)
		(!in_run && !wake) |=> (!address_strobe_line_out && !data_strobe_line_out && rw_n_out && bus_input_out))
		else $error("strobes not parked in low power");

	a_stop_holds: assert property (@(posedge clk_sys_in) disable iff (rst_in || por_in)
		(in_stop && irq_lvl_q) |=> in_stop)
		else $error("stop left without external interrupt");

	a_wait_timer_vec: assert property (@(posedge clk_sys_in) disable iff (rst_in || por_in)
		(in_wait && irq_lvl_q && tmr_req) |=> (irq_take_out && irq_vector_out == 13'h1ff6 && !wait_active_out))
		else $error("wait timer wake used wrong vector");

	a_hold_mode3: assert property (@(posedge clk_sys_in) disable iff (rst_in || por_in)
		(!pin_en_q && clk_sel_q && !wr_count) |=> $stable(count_q))
		else $error("count moved with inputs blocked");

	a_pre_clear: assert property (@(posedge clk_sys_in) disable iff (rst_in || por_in)
		pre_clear |=> (pre_q == '0))
		else $error("prescaler not zeroed");

	a_soft_masked: assert property (@(posedge clk_sys_in) disable iff (rst_in || por_in)
		(run_pick && soft_trap_op_in && !ext_pend && !tmr_pend) |=> (irq_take_out && irq_vector_out == 13'h1ffc))
		else $error("soft trap not vectored");

	a_stop_wake: assert property (@(posedge clk_sys_in) disable iff (rst_in || por_in)
		(in_stop && ext_low) |=> (wake_out && irq_take_out && irq_vector_out == 13'h1ffa && !stop_active_out))
		else $error("stop not left on external interrupt");

	a_ext_take: assert property (@(posedge clk_sys_in) disable iff (rst_in || por_in)
		(run_pick && ext_pend) |=> (irq_take_out && set_i_mask_out && irq_vector_out == 13'h1ffa))
		else $error("external interrupt not taken");

	a_timer_vec: assert property (@(posedge clk_sys_in) disable iff (rst_in || por_in)
		(run_pick && tmr_pend && !ext_pend) |=> (irq_take_out && set_i_mask_out && irq_vector_out == 13'h1ff8))
		else $error("timer interrupt not on normal vector");

	a_wait_entry: assert property (@(posedge clk_sys_in) disable iff (rst_in || por_in)
		(wait_go && !stop_op_in) |=> (in_wait && clear_i_mask_out && hold_addr_out && wait_active_out))
		else $error("wait entry did not release the mask");

endmodule

// ---- tb/tilu_core_model.sv ----
// core sequencer model: instruction clock, boundaries, mask bit and ops
module tilu_core_model (
	// clock and reset
	input  wire logic clk_sys_in,
	input  wire logic rst_in,
	// requests from the bench
	input  wire logic rti_in,
	input  wire logic stop_req_in,
	input  wire logic wait_req_in,
	input  wire logic trap_req_in,
	// answers from the unit
	input  wire logic set_i_mask_in,
	input  wire logic clear_i_mask_in,
	input  wire logic stop_active_in,
	input  wire logic wait_active_in,
	// sequencer outputs
	output logic      cycle_tick_out,
	output logic      instr_boundary_out,
	output logic      i_mask_out,
	output logic      stop_op_out,
	output logic      wait_op_out,
	output logic      soft_trap_op_out,
	output logic      as_out,
	output logic      ds_out,
	output logic      rw_n_out
);
	logic [1:0] phase_q;
	logic [1:0] tick_cnt_q;
	wire        low_pwr = stop_active_in | wait_active_in;
	// instruction clock runs on in wait, halts in stop
	assign cycle_tick_out     = (phase_q == 2'h3) & ~stop_active_in;
	// no instruction ends while the core sleeps
	assign instr_boundary_out = cycle_tick_out & (tick_cnt_q == 2'h3) & ~low_pwr;
	assign stop_op_out        = instr_boundary_out & stop_req_in;
	assign wait_op_out        = instr_boundary_out & wait_req_in;
	assign soft_trap_op_out   = instr_boundary_out & trap_req_in;
	assign as_out             = cycle_tick_out & ~low_pwr;
	assign ds_out             = (phase_q == 2'h1) & ~low_pwr;
	assign rw_n_out           = 1'b1;
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			phase_q    <= 2'h0;
			tick_cnt_q <= 2'h0;
			i_mask_out <= 1'b1;
		end else begin
			phase_q <= phase_q + 2'h1;
			if (cycle_tick_out)
				tick_cnt_q <= tick_cnt_q + 2'h1;
			if (set_i_mask_in)
				i_mask_out <= 1'b1;
			else if (clear_i_mask_in | rti_in)
				i_mask_out <= 1'b0;
		end
	end
endmodule

// ---- tb/test_tilu_timer_irq.sv ----
// self-checking bench for the timer, interrupt and low-power unit
module test_tilu_timer_irq;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys_in = 1'b0;
	logic        rst_in     = 1'b1;
	logic        por_in     = 1'b1;
	logic [7:0]  addr       = 8'h00;
	logic [7:0]  wdata      = 8'h00;
	logic        wr = 1'b0, rd = 1'b0, irq_n = 1'b1, tpin = 1'b0, trap_return_op = 1'b0;
	logic        sreq = 1'b0, wreq = 1'b0, treq = 1'b0;
	logic [7:0]  rdata, v;
	logic        tick, bnd, imask, sop, wop, top, cas, cds, crw;
	logic        take, set_i, clr_i, wake, as_o, ds_o, rw_o, bus_i, hold, stop_a, wait_a;
	logic [12:0] vec;
	int          fail_count = 0;
	int          n_compared = 0;
	int          n_take     = 0;
	int          c;

	tilu_timer_irq i_tilu_timer_irq (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .por_in(por_in),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.irq_n_in(irq_n), .timer_pin_in(tpin), .cycle_tick_in(tick), .instr_boundary_in(bnd),
		.i_mask_in(imask), .soft_trap_op_in(top), .stop_op_in(sop), .wait_op_in(wop),
		.core_as_in(cas), .core_ds_in(cds), .core_rw_n_in(crw), .irq_take_out(take),
		.irq_vector_out(vec), .set_i_mask_out(set_i), .clear_i_mask_out(clr_i), .wake_out(wake),
		.address_strobe_line_out(as_o), .data_strobe_line_out(ds_o), .rw_n_out(rw_o),
		.bus_input_out(bus_i), .hold_addr_out(hold), .stop_active_out(stop_a), .wait_active_out(wait_a));
	tilu_core_model i_tilu_core_model (.clk_sys_in(clk_sys_in), .rst_in(rst_in | por_in), .rti_in(trap_return_op),
		.stop_req_in(sreq), .wait_req_in(wreq), .trap_req_in(treq), .set_i_mask_in(set_i),
		.clear_i_mask_in(clr_i), .stop_active_in(stop_a), .wait_active_in(wait_a),
		.cycle_tick_out(tick), .instr_boundary_out(bnd), .i_mask_out(imask), .stop_op_out(sop),
		.wait_op_out(wop), .soft_trap_op_out(top), .as_out(cas), .ds_out(cds), .rw_n_out(crw));

	always #4 clk_sys_in = ~clk_sys_in;
	always @(posedge clk_sys_in) if (take === 1'b1) n_take <= n_take + 1;

	task automatic chk(input string name, input logic [12:0] exp, input logic [12:0] got);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	// prescaler phase against the bench is not pinned, so counts may be one off
	task automatic near(input string name, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp && got !== exp + 8'h01 && got !== exp - 8'h01) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk_sys_in);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk_sys_in);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk_sys_in);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
		rd_reg(a);
		chk(name, {5'h00, exp}, {5'h00, v});
	endtask
	task automatic take_chk(input logic [12:0] exp);
		for (int k = 0; k < 400 && take !== 1'b1; k++) @(posedge clk_sys_in);
		chk("vector", exp, (take === 1'b1) ? vec : 'x);
		@(posedge clk_sys_in);
	endtask
	task automatic ret;
		@(posedge clk_sys_in);
		trap_return_op <= 1'b1;
		@(posedge clk_sys_in);
		trap_return_op <= 1'b0;
	endtask
	task automatic no_take(input int n);
		c = n_take;
		cyc(n);
		chk("no_take", 13'(c), 13'(n_take));
	endtask
	task automatic finish_test;
		if (fail_count == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		#200000;
		fail_count++;
		finish_test;
	end

	initial begin
		cyc(2);
		rst_in <= 1'b0;
		por_in <= 1'b0;
		rchk("count", 8'h08, 8'hff);
		rchk("control", 8'h09, 8'h40);
		rchk("unmapped", 8'h0a, 8'h00);
		wr_reg(8'h09, 8'h60);
		wr_reg(8'h08, 8'h05);
		cyc(40);
		rchk("count", 8'h08, 8'h05);
		rchk("count", 8'h08, 8'h05);
		for (int p = 0; p < 8; p++) begin
			wr_reg(8'h09, 8'h48 | 8'(p));
			wr_reg(8'h08, 8'h80);
			rchk("control", 8'h09, 8'h40 | 8'(p));
			cyc((8 << p) - 2);
			rd_reg(8'h08);
			near("count", 8'h7e, v);
		end
		wr_reg(8'h09, 8'h48);
		wr_reg(8'h08, 8'h01);
		cyc(38);
		rd_reg(8'h08);
		near("count", 8'hf6, v);
		rchk("control", 8'h09, 8'hc0);
		ret;
		wr_reg(8'h09, 8'h00);
		no_take(60);
		wr_reg(8'h08, 8'h03);
		take_chk(13'h1ff8);
		chk("i_mask", 13'h1, {12'h0, imask});
		wr_reg(8'h09, 8'h00);
		irq_n <= 1'b0;
		no_take(60);
		ret;
		take_chk(13'h1ffa);
		ret;
		take_chk(13'h1ffa);
		irq_n <= 1'b1;
		cyc(8);
		ret;
		treq <= 1'b1;
		take_chk(13'h1ffc);
		treq <= 1'b0;
		wr_reg(8'h08, 8'h02);
		irq_n <= 1'b0;
		cyc(40);
		ret;
		take_chk(13'h1ffa);
		irq_n <= 1'b1;
		cyc(8);
		ret;
		take_chk(13'h1ff8);
		wr_reg(8'h09, 8'h40);
		irq_n <= 1'b0;
		treq  <= 1'b1;
		take_chk(13'h1ffc);
		treq <= 1'b0;
		ret;
		treq <= 1'b1;
		take_chk(13'h1ffa);
		take_chk(13'h1ffc);
		treq  <= 1'b0;
		irq_n <= 1'b1;
		wr_reg(8'h09, 8'h08);
		wr_reg(8'h08, 8'h30);
		wreq <= 1'b1;
		for (int k = 0; k < 100 && wait_a !== 1'b1; k++) @(posedge clk_sys_in);
		wreq <= 1'b0;
		chk("lp_pins", 13'h07, {8'h0, as_o, ds_o, rw_o, bus_i, hold});
		cyc(2);
		chk("i_mask", 13'h0, {12'h0, imask});
		take_chk(13'h1ff6);
		chk("wait_active", 13'h0, {12'h0, wait_a});
		wr_reg(8'h09, 8'hc0);
		wreq <= 1'b1;
		cyc(40);
		wreq  <= 1'b0;
		irq_n <= 1'b0;
		take_chk(13'h1ffa);
		irq_n <= 1'b1;
		cyc(8);
		wr_reg(8'h09, 8'h80);
		ret;
		take_chk(13'h1ff8);
		wr_reg(8'h09, 8'h80);
		sreq <= 1'b1;
		for (int k = 0; k < 100 && stop_a !== 1'b1; k++) @(posedge clk_sys_in);
		sreq <= 1'b0;
		chk("lp_pins", 13'h07, {8'h0, as_o, ds_o, rw_o, bus_i, hold});
		rchk("control", 8'h09, 8'h40);
		wr_reg(8'h09, 8'h80);
		no_take(60);
		irq_n <= 1'b0;
		take_chk(13'h1ffa);
		irq_n <= 1'b1;
		wr_reg(8'h09, 8'h78);
		wr_reg(8'h08, 8'h20);
		for (int k = 0; k < 5; k++) begin
			tpin <= 1'b1;
			cyc(8);
			tpin <= 1'b0;
			cyc(8);
		end
		rchk("count", 8'h08, 8'h1b);
		wr_reg(8'h09, 8'h58);
		wr_reg(8'h08, 8'h40);
		cyc(40);
		rchk("count", 8'h08, 8'h40);
		tpin <= 1'b1;
		cyc(40);
		tpin <= 1'b0;
		cyc(8);
		rd_reg(8'h08);
		near("count", 8'h36, v);
		wr_reg(8'h09, 8'hb7);
		rst_in <= 1'b1;
		cyc(2);
		rst_in <= 1'b0;
		rchk("control", 8'h09, 8'h77);
		por_in <= 1'b1;
		cyc(2);
		por_in <= 1'b0;
		rchk("count", 8'h08, 8'hff);
		finish_test;
	end
endmodule
